// [rtl/air_regs.svh]
// Purpose: Register offsets, field positions and reset values.
// Assumes: Included by bare name from the design files.
// Notes: Byte-wide register address, as on the serial interface.
`ifndef AIR_REGS_SVH
`define AIR_REGS_SVH
`define AIR_ADDR_MODE 8'h02
`define AIR_ADDR_CHECK 8'h03
`define AIR_ADDR_RESULT 8'h04
`define AIR_ADDR_STATUS 8'h00
`define AIR_BIT_WL 0
`define AIR_BIT_WATCH 5
`define AIR_BIT_APPEND 6
`define AIR_FLD_XFER_LO 2
`define AIR_MODE_RST 16'h0000
`define AIR_MODE_WMASK 16'h1FED
`define AIR_CHECK_RST 24'h00_0000
`define AIR_RESULT_RST 24'h00_0000
`define AIR_NUM_USER 4
`endif

// [rtl/air_pkg.sv]
// Purpose: Types shared by the register bank.
// Assumes: Nothing.
// Notes: None.
package air_pkg;
    typedef enum logic [1:0]
    {
        AIR_XFER_OFF = 2'h0,
        AIR_XFER_XOR = 2'h1,
        AIR_XFER_CRC = 2'h2,
        AIR_XFER_RSV = 2'h3
    } air_xfer_t;
    typedef enum logic [1:0]
    {
        AIR_RD_IDLE = 2'h0,
        AIR_RD_BUSY = 2'h1
    } air_rd_t;
endpackage

// [rtl/air_user_mem.sv]
// Purpose: Small store for the checked user registers.
// Assumes: One write port, one registered read port.
// Notes: Words are 24 bits; unused upper bits kept zero by the writer.
module air_user_mem
    import air_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int AW = 2
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [23:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [23:0] rd_data_out,
    output logic [24*DEPTH-1:0] all_out
);
    logic [23:0] mem_ff [DEPTH];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_word
            always_ff @(posedge ref_clk_in)
            begin
                if (rst_in)
                    mem_ff[g] <= 24'h00_0000;
                else if (wr_en_in && wr_addr_in == AW'(g))
                    mem_ff[g] <= wr_data_in;
            end
            assign all_out[24*g +: 24] = mem_ff[g];
        end
    endgenerate
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            rd_data_out <= 24'h00_0000;
        else
            rd_data_out <= mem_ff[rd_addr_in];
    end
endmodule

// [rtl/air_xor_fold.sv]
// Purpose: XOR fold of all checked user registers into one word.
// Assumes: Input is a flat concatenation of 24-bit words.
// Notes: Registered so the fold is not a long path into the bank.
module air_xor_fold
    import air_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [24*DEPTH-1:0] words_in,
    output logic [23:0] sum_out
);
    logic [23:0] fold;
    always_comb
    begin
        fold = 24'h00_0000;
        for (int i = 0; i < DEPTH; i++)
            fold = fold ^ words_in[24*i +: 24];
    end
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            sum_out <= 24'h00_0000;
        else
            sum_out <= fold;
    end
endmodule

// [rtl/air_bank.sv]
// Purpose: Interface mode fields, integrity checker and result register.
// Assumes: Serial framing done outside; one access per req pulse.
// Notes: Read data registered; answered two cycles after the request.
`include "air_regs.svh"
// Notes on behaviour
// [R1] With watch enabled, any change of a checked register sets the fault.
// [R2] Writing watch enable to zero clears the fault flag.
// [R3] Mode, result and status registers are not watched.
// [R4] Host configures everything first, then sets watch enable.
// [R5] Writing a checked register while watching raises the fault.
// [R6] Check select: 00 none, 01 xor reads and crc writes, 10 crc.
// [R7] Protected transfers carry one extra check byte.
// [R8] Short word select: 0 gives 24-bit result, 1 gives 16-bit.
// [R9] Mode writes do not reset conversion; next result has new length.
// [R10] Checksum register is the 24-bit XOR of watched registers, read only.
// [R11] Checksum reads zero while watch enable is clear.
// [R12] Result coding offset binary, or unipolar when polarity select says.
// [R13] Reading the result drives pending bit and pending output high.
// [R14] Result may be read repeatedly; same value until a new load.
// [R15] No new result is loaded while a result read is in progress.
// [R16] Append state select adds the status byte to every result read.
// [R17] Host writes zero to reserved mode bits 4 and 1.
// [R18] Checksum recomputed from current register contents before next read.
// [R19] Short word with append returns 16-bit result then status byte.
module air_bank
    import air_pkg::*;
#(
    parameter int NUM_USER = `AIR_NUM_USER,
    parameter int UAW = 2
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [23:0] wdata_in,
    input wire logic rd_done_in,
    input wire logic conv_valid_in,
    input wire logic [23:0] conv_code_in,
    input wire logic polarity_select_in,
    input wire logic [7:0] status_in,
    output logic ack_out,
    output logic [31:0] rdata_out,
    output logic [2:0] rlen_out,
    output logic check_byte_out,
    output logic [1:0] xfer_check_out,
    output logic short_word_out,
    output logic append_out,
    output logic integrity_fault_out,
    output logic result_pending_n_out,
    output logic mode_out_valid_out,
    output logic [15:0] mode_out
);
    logic [15:0] mode_ff;
    logic [15:0] nxt_mode;
    logic fault_ff;
    logic nxt_fault;
    logic [23:0] result_ff;
    logic [23:0] nxt_result;
    logic pend_n_ff;
    logic nxt_pend_n;
    logic held_ff;
    logic held_wl_ff;
    logic rd_busy_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [2:0] rlen_ff;
    logic [23:0] sum_q;
    logic [23:0] sum_prev_ff;
    logic watch_d1_ff;
    logic [23:0] user_rd;
    logic [24*NUM_USER-1:0] user_all;
    air_xfer_t xfer_sel;

    function automatic logic is_user(input logic [7:0] a);
        is_user = a >= 8'h10 && a < 8'h10 + 8'(NUM_USER);
    endfunction

    wire wr_req = req_in && wr_in;
    wire rd_req = req_in && !wr_in;
    wire wr_mode = wr_req && addr_in == `AIR_ADDR_MODE;
    wire wr_user = wr_req && is_user(addr_in); // [R3]
    wire rd_result = rd_req && addr_in == `AIR_ADDR_RESULT;
    wire watch_on = mode_ff[`AIR_BIT_WATCH];
    wire short_word_select = mode_ff[`AIR_BIT_WL];
    wire append_on = mode_ff[`AIR_BIT_APPEND];
    wire [UAW-1:0] uaddr = UAW'(addr_in - 8'h10);
    // Reserved bits 4 and 1 dropped even if the host ignores them
    wire [15:0] mode_wr = wdata_in[15:0] & `AIR_MODE_WMASK; // [R17]
    wire watch_clr = wr_mode && !mode_wr[`AIR_BIT_WATCH]; // [R2]
    // Fold compared against value captured when watching began
    // A lasting mismatch must not outlive the write that clears the watch
    wire sum_moved = watch_on && watch_d1_ff && !watch_clr &&
        sum_q != sum_prev_ff;
    wire fault_set = (watch_on && wr_user) || sum_moved; // [R1] [R5]
    // A read freezes the result until the framer ends the transfer
    wire load_ok = conv_valid_in && !rd_busy_ff && !rd_result; // [R15]
    // Unipolar when selected; offset binary is the native code
    wire [23:0] coded = polarity_select_in ?
        {~conv_code_in[23], conv_code_in[22:0]} : conv_code_in; // [R12]
    // Length follows the mode at load time, not at read time
    wire [23:0] shaped = short_word_select ? {8'h00, coded[23:8]} : coded; // [R8] [R9]
    wire res16 = held_wl_ff;
    wire [23:0] check_val = watch_on ? sum_q : 24'h00_0000; // [R10] [R11]
    wire [31:0] res_word = res16 ?
        (append_on ? {8'h00, result_ff[15:0], status_in} // [R19]
                   : {16'h0000, result_ff[15:0]}) :
        (append_on ? {result_ff, status_in} // [R16]
                   : {8'h00, result_ff});
    wire [2:0] res_len = 3'(res16 ? 2 : 3) + 3'(append_on ? 1 : 0);
    wire [31:0] rd_mux =
        addr_in == `AIR_ADDR_MODE ? {16'h0000, mode_ff} :
        addr_in == `AIR_ADDR_CHECK ? {8'h00, check_val} :
        addr_in == `AIR_ADDR_RESULT ? res_word :
        addr_in == `AIR_ADDR_STATUS ? {24'h00_0000, status_in} :
        is_user(addr_in) ? {8'h00, user_rd} : 32'h0000_0000;
    wire [2:0] len_mux =
        addr_in == `AIR_ADDR_MODE ? 3'h2 :
        addr_in == `AIR_ADDR_RESULT ? res_len :
        addr_in == `AIR_ADDR_STATUS ? 3'h1 : 3'h3;

    assign xfer_sel = air_xfer_t'(mode_ff[`AIR_FLD_XFER_LO +: 2]);
    assign nxt_mode = wr_mode ? mode_wr : mode_ff;
    // Set wins if it arrives in the clearing cycle
    assign nxt_fault = fault_set ? 1'b1 : (watch_clr ? 1'b0 : fault_ff);
    assign nxt_result = load_ok ? shaped : result_ff; // [R14]
    assign nxt_pend_n = rd_result ? 1'b1 :
        (load_ok ? 1'b0 : pend_n_ff); // [R13]

    // Peek reads the addressed word in the cycle of the request
    air_user_mem #(.DEPTH(NUM_USER), .AW(UAW)) u_mem
    (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_en_in(wr_user),
        .wr_addr_in(uaddr),
        .wr_data_in(wdata_in),
        .rd_addr_in(uaddr),
        .rd_data_out(),
        .all_out(user_all)
    );
    assign user_rd = user_all[24*uaddr +: 24];

    air_xor_fold #(.DEPTH(NUM_USER)) u_fold
    (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .words_in(user_all),
        .sum_out(sum_q)
    ); // [R18]

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            mode_ff <= `AIR_MODE_RST;
            fault_ff <= 1'b0;
            result_ff <= `AIR_RESULT_RST;
            pend_n_ff <= 1'b1;
            held_wl_ff <= 1'b0;
            held_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            fault_ff <= nxt_fault;
            result_ff <= nxt_result;
            pend_n_ff <= nxt_pend_n;
            held_ff <= held_ff | load_ok;
            if (load_ok)
                held_wl_ff <= short_word_select;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            rd_busy_ff <= 1'b0;
            watch_d1_ff <= 1'b0;
            sum_prev_ff <= `AIR_CHECK_RST;
        end
        else
        begin
            if (rd_result)
                rd_busy_ff <= 1'b1;
            else if (rd_done_in)
                rd_busy_ff <= 1'b0;
            watch_d1_ff <= watch_on;
            // Reference follows the fold every cycle until armed; held while watching
            if (!watch_d1_ff)
                sum_prev_ff <= sum_q;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rlen_ff <= 3'h0;
        end
        else
        begin
            ack_ff <= req_in;
            if (rd_req)
            begin
                rdata_ff <= rd_mux;
                rlen_ff <= len_mux;
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            ack_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            rlen_out <= 3'h0;
            check_byte_out <= 1'b0;
            xfer_check_out <= 2'h0;
            short_word_out <= 1'b0;
            append_out <= 1'b0;
            integrity_fault_out <= 1'b0;
            result_pending_n_out <= 1'b1;
            mode_out_valid_out <= 1'b0;
            mode_out <= 16'h0000;
        end
        else
        begin
            ack_out <= ack_ff;
            rdata_out <= rdata_ff;
            rlen_out <= rlen_ff;
            check_byte_out <= xfer_sel != AIR_XFER_OFF; // [R7]
            xfer_check_out <= xfer_sel; // [R6]
            short_word_out <= short_word_select;
            append_out <= append_on;
            integrity_fault_out <= fault_ff;
            result_pending_n_out <= pend_n_ff;
            mode_out_valid_out <= held_ff;
            mode_out <= mode_ff;
        end
    end
endmodule

// [test/air_bank_checker.sv]
// Purpose: Port-level assertions for the register bank.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Bound to every air_bank instance.
module air_bank_checker
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [23:0] wdata_in,
    input wire logic ack_out,
    input wire logic [31:0] rdata_out,
    input wire logic [2:0] rlen_out,
    input wire logic check_byte_out,
    input wire logic [1:0] xfer_check_out,
    input wire logic short_word_out,
    input wire logic append_out,
    input wire logic integrity_fault_out,
    input wire logic result_pending_n_out,
    input wire logic [15:0] mode_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    sequence rd_s(a);
        req_in && !wr_in && addr_in == a;
    endsequence
    sequence user_wr_s;
        req_in && wr_in && addr_in[7:2] == 6'h04;
    endsequence
    // Mode output trails the register by a cycle; skip the cycle after
    // a mode write so back-to-back requests are not misjudged
    wire mode_wr = req_in && wr_in && addr_in == 8'h02;
    xfer_field_a: assert property (xfer_check_out == mode_out[3:2])
        else $error("check select differs from mode field");
    check_byte_a: assert property (check_byte_out == |xfer_check_out)
        else $error("extra check byte flag wrong");
    short_word_a: assert property (short_word_out == mode_out[0])
        else $error("short word flag differs from mode");
    append_bit_a: assert property (append_out == mode_out[6])
        else $error("append flag differs from mode");
    mode_rsv_a: assert property (!mode_out[4] && !mode_out[1])
        else $error("reserved mode bits not zero");
    fault_set_a: assert property (user_wr_s and (mode_out[5]
        && !$past(mode_wr)) |-> ##[1:3] integrity_fault_out)
        else $error("no fault after watched write");
    fault_clear_a: assert property (mode_wr && !wdata_in[5]
        |-> ##2 !integrity_fault_out)
        else $error("fault not cleared");
    pend_high_a: assert property (rd_s(8'h04)
        |-> ##2 result_pending_n_out)
        else $error("pending not released by read");
    res_len_a: assert property (rd_s(8'h04) ##2 ack_out
        |-> rlen_out == (short_word_out ? 3'h2 : 3'h3) + 3'(append_out))
        else $error("result length wrong");
    sum_zero_a: assert property (rd_s(8'h03) and (!mode_out[5]
        && !$past(mode_wr)) |-> ##2 rdata_out == 32'h0000_0000)
        else $error("checksum not zero while unwatched");
endmodule

bind air_bank air_bank_checker i_chk (.ref_clk_in, .rst_in, .req_in,
    .wr_in, .addr_in, .wdata_in, .ack_out, .rdata_out, .rlen_out,
    .check_byte_out, .xfer_check_out, .short_word_out, .append_out,
    .integrity_fault_out, .result_pending_n_out, .mode_out);

// [test/air_host.sv]
// Purpose: Host model issuing single register accesses.
// Assumes: One request pulse, then wait for the answer.
// Notes: Released address and data lines show inverted values, there is no pull.
module air_host
(
    input wire logic ref_clk_in,
    input wire logic ack_in,
    input wire logic [31:0] rdata_in,
    output logic req_out = 0,
    output logic wr_out = 0,
    output logic [7:0] addr_out = 8'h00,
    output logic [23:0] wdata_out = 24'h00_0000
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic access(input logic w, input logic [7:0] a,
        input logic [23:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(negedge ref_clk_in);
        req_out = 1;
        wr_out = w;
        addr_out = a;
        // Host never sets reserved mode bits
        wdata_out = (a == 8'h02) ? d & 24'hFF_FFED : d;
        @(negedge ref_clk_in);
        req_out = 0;
        addr_out = ~a;
        wdata_out = ~wdata_out;
        while (ack_in !== 1'b1 && n < 6)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        q = rdata_in;
    endtask
endmodule

// [test/air_bank_tb_top.sv]
// Purpose: Self-checking bench for the register bank.
// Assumes: Host model drives the register port.
// Notes: Expected values come from a small model held in logic vectors.
module air_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, rdd = 0, cv = 0, pol = 0;
    logic [23:0] code = 24'h00_0000;
    logic [7:0] st = 8'h00;
    wire req, wr, ack, cb, sw, ap, flt, pnd_n, mv;
    wire [7:0] addr;
    wire [23:0] wd;
    wire [31:0] rd;
    wire [2:0] rl;
    wire [1:0] xc;
    wire [15:0] mo;
    logic [31:0] q, seed = 32'h0000_0011;
    logic [23:0] u [4], r;
    logic [15:0] m;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    always #2.5 clk = ~clk;
    air_host i_host (.ref_clk_in(clk), .ack_in(ack), .rdata_in(rd),
        .req_out(req), .wr_out(wr), .addr_out(addr), .wdata_out(wd));
    air_bank i_dut (.ref_clk_in(clk), .rst_in(rst), .req_in(req),
        .wr_in(wr), .addr_in(addr), .wdata_in(wd), .rd_done_in(rdd),
        .conv_valid_in(cv), .conv_code_in(code),
        .polarity_select_in(pol), .status_in(st), .ack_out(ack),
        .rdata_out(rd), .rlen_out(rl), .check_byte_out(cb),
        .xfer_check_out(xc), .short_word_out(sw), .append_out(ap),
        .integrity_fault_out(flt), .result_pending_n_out(pnd_n),
        .mode_out_valid_out(mv), .mode_out(mo));
    function automatic logic [23:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[23:0];
    endfunction
    function automatic logic [31:0] xr();
        return m[5] ? {8'h00, u[0] ^ u[1] ^ u[2] ^ u[3]} : 32'h0;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
        i_host.access(1'b1, a, d, q);
        if (a == 8'h02)
            m = d[15:0] & 16'h1FED;
    endtask
    task automatic rd_sum();
        i_host.access(1'b0, 8'h03, 24'h0, q);
        chk("checksum", xr(), q);
    endtask
    task automatic load(input logic keep);
        @(negedge clk);
        cv = 1;
        code = rnd();
        st = 8'(rnd());
        @(negedge clk);
        cv = 0;
        // A held result stays frozen while a read is open
        if (!keep) r = m[0] ? {8'h00, code[23:8]} : code;
        if (!keep && pol) r[m[0] ? 15 : 23] ^= 1'b1;
        code = ~code;
        // Pending output trails the load by one more cycle
        @(negedge clk);
        chk("pending_n", keep, pnd_n);
        chk("loaded", 1, mv);
    endtask
    task automatic rd_res(input logic done);
        i_host.access(1'b0, 8'h04, 24'h0, q);
        chk("result", m[6] ? (m[0] ? {8'h0, r[15:0], st} : {r, st})
            : {8'h00, r}, q);
        chk("rlen", (m[0] ? 3'h2 : 3'h3) + m[6], rl);
        chk("pending_n", 1, pnd_n);
        @(negedge clk);
        rdd = done;
        @(negedge clk);
        rdd = 0;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        // Whole run needs well under a thousand cycles
        if (cyc == 4000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        m = 0;
        r = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 0;
        chk("mode", 0, mo);
        chk("loaded", 0, mv);
        rd_sum();
        rd_res(1);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            u[i] = rnd();
            wr_reg(8'h10 + i, u[i]);
        end
        rd_sum();
        wr_reg(8'h02, 24'h00_0020);
        rd_sum();
        wr_reg(8'h03, rnd());
        rd_sum();
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(8'h02, 24'h20 | k << 2);
            chk("xfer", k, xc);
            chk("check_byte", k != 0, cb);
        end
        chk("fault", 0, flt);
        $display("test checksum done");
        for (int j = 0; j < 4; j++)
        begin
            // Bit 0 picks the short word, bit 6 appends status
            wr_reg(8'h02, {17'h0_0000, j[1], 5'h10, j[0]});
            pol = j == 1;
            load(0);
            rd_res(1);
            rd_res(1);
        end
        chk("fault", 0, flt);
        $display("test result done");
        rd_res(0);
        load(1);
        rd_res(1);
        load(0);
        rd_res(1);
        $display("test freeze done");
        u[1] = rnd();
        wr_reg(8'h11, u[1]);
        chk("fault", 1, flt);
        rd_sum();
        wr_reg(8'h02, 24'h00_0000);
        chk("fault", 0, flt);
        rd_sum();
        $display("test fault done");
        print_verdict();
    end
endmodule
